// ==== uc_top.sv ====
// Serial port configuration registers, interrupt requests, line coding and baud timing
`timescale 1ns/1ns
`include "uc_regs.svh"

// Contract
// - Receive-full request only while its enable set
// - Transmit-empty request only while its enable set
// - Threshold bit: fire at two bytes, else one
// - Port runs only while enable bit set
// - Infrared bit selects pulse line coding
// - Eight-bit divisor sets baud underflow period
// - Trim inserts extra delays per 16 underflows
// - Source field: fast, slow, reserved, external
// - Fast source divided by 1, 2, 4, 8
// - Gate bit passes port clock only when set
module uc_top (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [15:0] bus_addr,
  input wire uc_pkg::uc_byte_t bus_wdata,
  input wire logic bus_we,
  input wire logic bus_re,
  output uc_pkg::uc_byte_t bus_rdata,
  input wire logic fast_oscillator,
  input wire logic slow_oscillator,
  input wire logic ext_clock,
  input wire logic [1:0] rx_count,
  input wire logic tx_buf_empty,
  input wire logic tx_line,
  input wire logic rx_pin,
  output logic irq,
  output logic rx_full_req,
  output logic tx_empty_req,
  output logic bit_tick,
  output logic port_active,
  output logic infrared_mode,
  output logic tx_pin,
  output logic rx_line
);

  // ****************************************
  // Declarations
  // ****************************************
  uc_pkg::uc_byte_t ctl_r;
  uc_pkg::uc_byte_t exp_r;
  uc_pkg::uc_byte_t br_r;
  uc_pkg::uc_byte_t fmd_r;
  uc_pkg::uc_byte_t clk_r;
  uc_pkg::uc_byte_t irq_st_r;
  uc_pkg::uc_byte_t irq_msk_r;
  uc_pkg::uc_byte_t rdata_r;
  uc_pkg::uc_byte_t rdata_nxt;
  uc_pkg::uc_byte_t irq_st_nxt;
  uc_pkg::uc_byte_t irq_clr;
  uc_pkg::uc_byte_t irq_set;
  logic rx_full_req_r;
  logic tx_empty_req_r;
  logic rx_full_req_nxt;
  logic tx_empty_req_nxt;
  logic irq_r;
  logic irq_nxt;
  logic tx_pin_r;
  logic tx_pin_nxt;
  logic rx_line_r;
  logic rx_line_nxt;
  logic rx_sync1_r;
  logic rx_sync2_r;
  logic ir_low_seen_r;
  logic ir_low_seen_nxt;
  logic port_tick;
  logic baud_bit_tick;
  uc_pkg::uc_phase_t baud_phase;

  logic hit_ctl;
  logic hit_exp;
  logic hit_br;
  logic hit_fmd;
  logic hit_clk;
  logic hit_st;
  logic hit_msk;

  logic port_enable;
  logic rx_irq_threshold;
  logic tx_empty_irq_enable;
  logic rx_full_irq_enable;
  logic ir_on;
  uc_pkg::uc_src_t port_clock_source;
  logic [1:0] port_clock_divider;
  logic port_clock_gate;
  logic rx_level_met;
  logic ir_pulse_window;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic reg_hit(input logic [15:0] addr, input logic [15:0] target);
    reg_hit = (addr == target);
  endfunction

  // Writes keep only the implemented bits
  function automatic uc_pkg::uc_byte_t masked(input uc_pkg::uc_byte_t data, input uc_pkg::uc_byte_t mask);
    masked = data & mask;
  endfunction

  // ****************************************
  // Address decode
  // ****************************************
  assign hit_ctl = reg_hit(bus_addr, `UC_ADDR_CTL);
  assign hit_exp = reg_hit(bus_addr, `UC_ADDR_EXP);
  assign hit_br = reg_hit(bus_addr, `UC_ADDR_BR);
  assign hit_fmd = reg_hit(bus_addr, `UC_ADDR_FMD);
  assign hit_clk = reg_hit(bus_addr, `UC_ADDR_CLK);
  assign hit_st = reg_hit(bus_addr, `UC_ADDR_IRQ_ST);
  assign hit_msk = reg_hit(bus_addr, `UC_ADDR_IRQ_MSK);

  // ****************************************
  // Register fields
  // ****************************************
  assign port_enable = ctl_r[`UC_CTL_PORT_EN];
  assign rx_irq_threshold = ctl_r[`UC_CTL_RX_THR];
  assign tx_empty_irq_enable = ctl_r[`UC_CTL_TX_IEN];
  assign rx_full_irq_enable = ctl_r[`UC_CTL_RX_IEN];
  assign ir_on = exp_r[`UC_EXP_IR];
  assign port_clock_source = clk_r[`UC_CLK_SRC_HI:`UC_CLK_SRC_LO];
  assign port_clock_divider = clk_r[`UC_CLK_DIV_HI:`UC_CLK_DIV_LO];
  assign port_clock_gate = clk_r[`UC_CLK_GATE];

  // ****************************************
  // Read path
  // ****************************************
  // Unmapped addresses and reserved bits answer zero
  assign rdata_nxt = !bus_re ? `UC_RST_BYTE :
                     hit_ctl ? ctl_r :
                     hit_exp ? exp_r :
                     hit_br ? br_r :
                     hit_fmd ? fmd_r :
                     hit_clk ? clk_r :
                     hit_st ? irq_st_r :
                     hit_msk ? irq_msk_r : `UC_RST_BYTE;

  // ****************************************
  // Interrupt requests
  // ****************************************
  assign rx_level_met = rx_irq_threshold ? (rx_count >= `UC_RX_TWO) : (rx_count >= `UC_RX_ONE);
  assign rx_full_req_nxt = port_enable & rx_full_irq_enable & rx_level_met;
  assign tx_empty_req_nxt = port_enable & tx_empty_irq_enable & tx_buf_empty;

  // Sticky bits catch the rising edge of each request, so a level that stays high is seen once
  assign irq_set = {6'h00, rx_full_req_nxt & ~rx_full_req_r, tx_empty_req_nxt & ~tx_empty_req_r};
  assign irq_clr = (bus_we && hit_st) ? masked(bus_wdata, `UC_MASK_IRQ) : `UC_RST_BYTE;
  // Set wins over a clear in the same cycle
  assign irq_st_nxt = (irq_st_r & ~irq_clr) | irq_set;
  assign irq_nxt = |(irq_st_nxt & irq_msk_r);

  // ****************************************
  // Line coding
  // ****************************************
  // A zero bit goes out as a short high pulse in the first phases of the bit
  assign ir_pulse_window = (baud_phase < `UC_IR_PULSE_PHASES);
  assign tx_pin_nxt = !port_enable ? !ir_on :
                      ir_on ? (!tx_line && ir_pulse_window) : tx_line;
  // A received pulse marks the whole bit as zero until the next bit boundary
  assign ir_low_seen_nxt = (!port_enable || !ir_on) ? 1'b0 :
                           rx_sync2_r ? 1'b1 :
                           baud_bit_tick ? 1'b0 : ir_low_seen_r;
  assign rx_line_nxt = !port_enable ? 1'b1 :
                       ir_on ? !(ir_low_seen_r || rx_sync2_r) : rx_sync2_r;

  // ****************************************
  // Register storage
  // ****************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctl_r <= `UC_RST_BYTE;
      exp_r <= `UC_RST_BYTE;
      br_r <= `UC_RST_BYTE;
      fmd_r <= `UC_RST_BYTE;
      clk_r <= `UC_RST_BYTE;
      irq_msk_r <= `UC_RST_BYTE;
    end else if (bus_we) begin
      if (hit_ctl) begin
        ctl_r <= masked(bus_wdata, `UC_MASK_CTL);
      end
      if (hit_exp) begin
        exp_r <= masked(bus_wdata, `UC_MASK_EXP);
      end
      if (hit_br) begin
        br_r <= masked(bus_wdata, `UC_MASK_BR);
      end
      if (hit_fmd) begin
        fmd_r <= masked(bus_wdata, `UC_MASK_FMD);
      end
      if (hit_clk) begin
        clk_r <= masked(bus_wdata, `UC_MASK_CLK);
      end
      if (hit_msk) begin
        irq_msk_r <= masked(bus_wdata, `UC_MASK_IRQ);
      end
    end
  end

  // ****************************************
  // Status, read data and output flops
  // ****************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_st_r <= `UC_RST_BYTE;
      irq_r <= 1'b0;
      rx_full_req_r <= 1'b0;
      tx_empty_req_r <= 1'b0;
      rdata_r <= `UC_RST_BYTE;
    end else begin
      irq_st_r <= irq_st_nxt;
      irq_r <= irq_nxt;
      rx_full_req_r <= rx_full_req_nxt;
      tx_empty_req_r <= tx_empty_req_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ****************************************
  // Pin flops
  // ****************************************
  // Pin idles high in plain mode; in pulse mode the idle level is low
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_sync1_r <= 1'b1;
      rx_sync2_r <= 1'b1;
      ir_low_seen_r <= 1'b0;
      tx_pin_r <= 1'b1;
      rx_line_r <= 1'b1;
    end else begin
      rx_sync1_r <= rx_pin;
      rx_sync2_r <= rx_sync1_r;
      ir_low_seen_r <= ir_low_seen_nxt;
      tx_pin_r <= tx_pin_nxt;
      rx_line_r <= rx_line_nxt;
    end
  end

  // ****************************************
  // Clock source and baud timing
  // ****************************************
  uc_clkgen u_clkgen (
    .clk(clk),
    .arst_n(arst_n),
    .fast_oscillator(fast_oscillator),
    .slow_oscillator(slow_oscillator),
    .ext_clock(ext_clock),
    .port_clock_source(port_clock_source),
    .port_clock_divider(port_clock_divider),
    .port_clock_gate(port_clock_gate),
    .port_tick_r(port_tick)
  );

  // The counter is held at reload while the port is off, so enabling starts a clean bit
  uc_baud u_baud (
    .clk(clk),
    .arst_n(arst_n),
    .run(port_enable),
    .port_tick(port_tick),
    .baud_divisor_value(br_r),
    .fine_trim_count(fmd_r[3:0]),
    .bit_tick_r(baud_bit_tick),
    .phase_r(baud_phase)
  );

  // ****************************************
  // Outputs
  // ****************************************
  assign bus_rdata = rdata_r;
  assign irq = irq_r;
  assign rx_full_req = rx_full_req_r;
  assign tx_empty_req = tx_empty_req_r;
  assign bit_tick = baud_bit_tick;
  assign port_active = port_enable;
  assign infrared_mode = ir_on;
  assign tx_pin = tx_pin_r;
  assign rx_line = rx_line_r;

endmodule

// ==== uc_regs.svh ====
// Register addresses, field positions, reset values and fixed counts for the serial port config block
`ifndef UC_REGS_SVH
`define UC_REGS_SVH

// ****************************************
// Register addresses
// ****************************************
`define UC_ADDR_CTL 16'h4104
`define UC_ADDR_EXP 16'h4105
`define UC_ADDR_BR 16'h4106
`define UC_ADDR_FMD 16'h4107
`define UC_ADDR_IRQ_ST 16'h4108
`define UC_ADDR_IRQ_MSK 16'h4109
`define UC_ADDR_CLK 16'h506C

// ****************************************
// Writable bit masks, reserved bits read zero
// ****************************************
`define UC_MASK_CTL 8'h33
`define UC_MASK_EXP 8'h01
`define UC_MASK_BR 8'hFF
`define UC_MASK_FMD 8'h0F
`define UC_MASK_CLK 8'h3D
`define UC_MASK_IRQ 8'h03

// ****************************************
// Reset values
// ****************************************
`define UC_RST_BYTE 8'h00
`define UC_RST_NIB 4'h0
`define UC_RST_SRC 2'h0
`define UC_RST_DIV 2'h0
`define UC_RST_STAGE 3'h0

// ****************************************
// Field positions
// ****************************************
`define UC_CTL_PORT_EN 0
`define UC_CTL_RX_THR 1
`define UC_CTL_TX_IEN 4
`define UC_CTL_RX_IEN 5
`define UC_EXP_IR 0
`define UC_CLK_GATE 0
`define UC_CLK_SRC_LO 2
`define UC_CLK_SRC_HI 3
`define UC_CLK_DIV_LO 4
`define UC_CLK_DIV_HI 5
`define UC_IRQ_TX 0
`define UC_IRQ_RX 1

// ****************************************
// Codes and counts
// ****************************************
`define UC_SRC_FAST 2'h0
`define UC_SRC_SLOW 2'h1
`define UC_SRC_EXT 2'h3
`define UC_RX_ONE 2'h1
`define UC_RX_TWO 2'h2
`define UC_PHASE_LAST 4'hF
`define UC_IR_PULSE_PHASES 4'h3
`define UC_SYN_FAST 0
`define UC_SYN_SLOW 1
`define UC_SYN_EXT 2

`endif

// ==== uc_pkg.sv ====
// Shared types of the serial port config block
package uc_pkg;
  typedef logic [7:0] uc_byte_t;
  typedef logic [1:0] uc_src_t;
  typedef logic [3:0] uc_phase_t;
endpackage

// ==== uc_clkgen.sv ====
// Port clock selection, fast oscillator divider and gate, producing one tick per rising edge of the selected, divided source
`timescale 1ns/1ns
`include "uc_regs.svh"
module uc_clkgen (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic fast_oscillator,
  input wire logic slow_oscillator,
  input wire logic ext_clock,
  input wire uc_pkg::uc_src_t port_clock_source,
  input wire logic [1:0] port_clock_divider,
  input wire logic port_clock_gate,
  output logic port_tick_r
);
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic [2:0] last_r;
  logic [2:0] div_cnt_r;
  logic [2:0] rise;
  logic fast_pass;
  logic sel_tick;
  logic port_tick_nxt;

  function automatic logic [2:0] div_mask(input logic [1:0] code);
    div_mask = 3'((4'h1 << code) - 4'h1);
  endfunction

  // Sources are asynchronous to clk, so only the second stage is looked at
  assign rise = sync2_r & ~last_r;
  assign fast_pass = rise[`UC_SYN_FAST] && ((div_cnt_r & div_mask(port_clock_divider)) == `UC_RST_STAGE);
  assign sel_tick = (port_clock_source == `UC_SRC_FAST) ? fast_pass :
                    (port_clock_source == `UC_SRC_SLOW) ? rise[`UC_SYN_SLOW] :
                    (port_clock_source == `UC_SRC_EXT) ? rise[`UC_SYN_EXT] : 1'b0;
  assign port_tick_nxt = sel_tick & port_clock_gate;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_r <= `UC_RST_STAGE;
      sync2_r <= `UC_RST_STAGE;
      last_r <= `UC_RST_STAGE;
      div_cnt_r <= `UC_RST_STAGE;
      port_tick_r <= 1'b0;
    end else begin
      sync1_r <= {ext_clock, slow_oscillator, fast_oscillator};
      sync2_r <= sync1_r;
      last_r <= sync2_r;
      div_cnt_r <= rise[`UC_SYN_FAST] ? div_cnt_r + 3'h1 : div_cnt_r;
      port_tick_r <= port_tick_nxt;
    end
  end
endmodule

// ==== uc_baud.sv ====
// Baud counter with divisor reload and fine trim delays spread over each 16-underflow span
`timescale 1ns/1ns
`include "uc_regs.svh"
module uc_baud (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic run,
  input wire logic port_tick,
  input wire uc_pkg::uc_byte_t baud_divisor_value,
  input wire logic [3:0] fine_trim_count,
  output logic bit_tick_r,
  output uc_pkg::uc_phase_t phase_r
);
  uc_pkg::uc_byte_t cnt_r;
  logic [3:0] acc_r;
  logic delay_r;
  logic underflow;
  logic [4:0] acc_sum;

  assign underflow = port_tick && !delay_r && (cnt_r == `UC_RST_BYTE);
  // Accumulating the trim spreads the extra cycles evenly instead of bunching them
  assign acc_sum = {1'b0, acc_r} + {1'b0, fine_trim_count};

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= `UC_RST_BYTE;
      acc_r <= `UC_RST_NIB;
      delay_r <= 1'b0;
      phase_r <= `UC_RST_NIB;
      bit_tick_r <= 1'b0;
    end else if (!run) begin
      cnt_r <= baud_divisor_value;
      acc_r <= `UC_RST_NIB;
      delay_r <= 1'b0;
      phase_r <= `UC_RST_NIB;
      bit_tick_r <= 1'b0;
    end else begin
      bit_tick_r <= underflow && (phase_r == `UC_PHASE_LAST);
      if (port_tick && delay_r) begin
        delay_r <= 1'b0;
      end else if (underflow) begin
        cnt_r <= baud_divisor_value;
        acc_r <= acc_sum[3:0];
        delay_r <= acc_sum[4];
        phase_r <= phase_r + 4'h1;
      end else if (port_tick) begin
        cnt_r <= cnt_r - 8'h01;
      end
    end
  end
endmodule

// ==== uc_top_assertions.sv ====
// Concurrent checks on the serial port config block ports
`timescale 1ns/1ns
`include "uc_regs.svh"
module uc_top_assertions (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [15:0] bus_addr,
  input wire uc_pkg::uc_byte_t bus_wdata,
  input wire logic bus_we,
  input wire logic bus_re,
  input wire uc_pkg::uc_byte_t bus_rdata,
  input wire logic [1:0] rx_count,
  input wire logic tx_buf_empty,
  input wire logic tx_line,
  input wire logic rx_full_req,
  input wire logic tx_empty_req,
  input wire logic bit_tick,
  input wire logic port_active,
  input wire logic infrared_mode,
  input wire logic tx_pin
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ****************
  // Bus cycles and port checks
  // ****************
  sequence s_rd(a);
    bus_re && bus_addr == a;
  endsequence
  sequence s_wr(a);
    bus_we && bus_addr == a;
  endsequence
  AST_CTL_RSVD: assert property (s_rd(`UC_ADDR_CTL) |=> (bus_rdata & ~`UC_MASK_CTL) == 8'h00)
    else $error("control reserved bits not zero");
  AST_EXP_RSVD: assert property (s_rd(`UC_ADDR_EXP) |=> bus_rdata[7:1] == 7'h00)
    else $error("expansion reserved bits not zero");
  AST_PORT_EN: assert property (s_wr(`UC_ADDR_CTL) |=> port_active == $past(bus_wdata[0]))
    else $error("port enable not written");
  AST_IR_WR: assert property (s_wr(`UC_ADDR_EXP) |=> infrared_mode == $past(bus_wdata[0]))
    else $error("infrared bit not written");
  AST_RX_EMPTY: assert property (rx_count == 2'h0 |=> !rx_full_req)
    else $error("receive request with empty buffer");
  AST_TX_FULL: assert property (!tx_buf_empty |=> !tx_empty_req)
    else $error("transmit request with data pending");
  AST_REQ_OFF: assert property (!port_active |=> !rx_full_req && !tx_empty_req)
    else $error("request while port disabled");
  AST_TICK_PULSE: assert property (bit_tick |=> !bit_tick)
    else $error("bit tick longer than one cycle");
  AST_TICK_HALT: assert property (!port_active |=> !bit_tick)
    else $error("bit tick while port disabled");
  AST_TX_OFF: assert property (!port_active |=> tx_pin == !$past(infrared_mode))
    else $error("idle line level wrong");
  AST_TX_PLAIN: assert property (port_active && !infrared_mode |=> tx_pin == $past(tx_line))
    else $error("plain line not following transmitter");
  AST_IR_MARK: assert property (port_active && infrared_mode && tx_line |=> !tx_pin)
    else $error("infrared pulse on a one bit");
endmodule
bind uc_top uc_top_assertions u_chk (.clk(clk), .arst_n(arst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
  .bus_we(bus_we), .bus_re(bus_re), .bus_rdata(bus_rdata), .rx_count(rx_count), .tx_buf_empty(tx_buf_empty),
  .tx_line(tx_line), .rx_full_req(rx_full_req), .tx_empty_req(tx_empty_req), .bit_tick(bit_tick),
  .port_active(port_active), .infrared_mode(infrared_mode), .tx_pin(tx_pin));

// ==== uc_remote.sv ====
// Remote serial station model that echoes the line back
`timescale 1ns/1ns
module uc_remote (
  input wire logic clk,
  input wire logic slow,
  input wire logic line_in,
  output logic line_out
);
  logic [7:0] dly_r = 8'hFF;
  always @(posedge clk) begin
    dly_r <= {dly_r[6:0], line_in};
  end
  // A late station answers eight cycles behind, so decode must not assume a prompt echo
  assign line_out = slow ? dly_r[7] : dly_r[0];
endmodule

// ==== tb.sv ====
// Self-checking bench for the serial port config block
`timescale 1ns/1ns
`include "uc_regs.svh"
module tb;
  logic clk, arst_n, bus_we, bus_re, fast_oscillator, slow_oscillator, ext_clock, tx_buf_empty, tx_line;
  logic irq, rx_full_req, tx_empty_req, bit_tick, port_active, infrared_mode, tx_pin, rx_line, rx_pin, slow_echo;
  logic rd_taken = 1'b0;
  logic [15:0] bus_addr;
  logic [1:0] rx_count;
  uc_pkg::uc_byte_t bus_wdata, bus_rdata, v;
  uc_pkg::uc_byte_t exp_q[$];
  int num_errors, cmp_count, n, hi, lo;
  logic [15:0] adr[8] = '{`UC_ADDR_CTL, `UC_ADDR_EXP, `UC_ADDR_BR, `UC_ADDR_FMD, `UC_ADDR_IRQ_ST,
    `UC_ADDR_IRQ_MSK, `UC_ADDR_CLK, 16'h4103};
  uc_pkg::uc_byte_t msk[8] = '{8'h33, 8'h01, 8'hFF, 8'h0F, 8'h00, 8'h03, 8'h3D, 8'h00};
  // Divide by four, and a divider code that the slow source must ignore, are covered too
  uc_pkg::uc_byte_t bd[7] = '{8'h00, 8'h01, 8'h00, 8'h02, 8'h01, 8'h00, 8'h00};
  uc_pkg::uc_byte_t tr[7] = '{8'h00, 8'h03, 8'h00, 8'h0F, 8'h02, 8'h01, 8'h05};
  uc_pkg::uc_byte_t ck[7] = '{8'h01, 8'h11, 8'h31, 8'h05, 8'h21, 8'h35, 8'h0D};
  logic [15:0] gap[7] = '{16'h0040, 16'h0118, 16'h0200, 16'h01F8, 16'h0220, 16'h0088, 16'h00FC};
  uc_top dut (.clk(clk), .arst_n(arst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_we(bus_we),
    .bus_re(bus_re), .bus_rdata(bus_rdata), .fast_oscillator(fast_oscillator), .slow_oscillator(slow_oscillator),
    .ext_clock(ext_clock), .rx_count(rx_count), .tx_buf_empty(tx_buf_empty), .tx_line(tx_line), .rx_pin(rx_pin),
    .irq(irq), .rx_full_req(rx_full_req), .tx_empty_req(tx_empty_req), .bit_tick(bit_tick),
    .port_active(port_active), .infrared_mode(infrared_mode), .tx_pin(tx_pin), .rx_line(rx_line));
  uc_remote u_remote (.clk(clk), .slow(slow_echo), .line_in(tx_pin), .line_out(rx_pin));
  // ****************
  // Clocks
  // ****************
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Oscillators start off the clock grid so their edges stay unrelated to it
  initial begin
    #13;
    fork
      forever #200 fast_oscillator = ~fast_oscillator;
      forever #400 slow_oscillator = ~slow_oscillator;
      forever #600 ext_clock = ~ext_clock;
    join
  end
  // ****************
  // Tasks
  // ****************
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input uc_pkg::uc_byte_t d);
    @(posedge clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_we <= 1'b1;
    @(posedge clk);
    bus_we <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input uc_pkg::uc_byte_t e);
    @(posedge clk);
    bus_addr <= a;
    bus_re <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    bus_re <= 1'b0;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic stop_test();
    $display("num_errors=%0d cmp_count=%0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Bounded wait for the next bit tick, returns the cycles waited
  task automatic tick_gap(output int k);
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (bit_tick !== 1'b1 && k < 3000);
    if (bit_tick !== 1'b1) begin
      num_errors++;
      stop_test();
    end
  endtask
  // ****************
  // Read data monitor
  // ****************
  always @(posedge clk) rd_taken <= bus_re;
  always @(negedge clk) begin
    if (rd_taken === 1'b1 && exp_q.size() > 0) begin
      check(16'(bus_rdata), 16'(exp_q.pop_front()));
    end
  end
  // ****************
  // Main sequence
  // ****************
  initial begin
    void'($urandom(32'h60D61BA4));
    {bus_we, bus_re, fast_oscillator, slow_oscillator, ext_clock, tx_buf_empty, slow_echo} = 7'h00;
    {bus_addr, bus_wdata, rx_count, tx_line, arst_n} = 28'h0000002;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd(adr[i], 8'h00);
      wr(adr[i], 8'hFF);
      rd(adr[i], msk[i]);
      wr(adr[i], 8'h00);
    end
    repeat (4) begin
      v = 8'($urandom);
      wr(`UC_ADDR_BR, v);
      rd(`UC_ADDR_BR, v);
      wr(`UC_ADDR_FMD, v);
      rd(`UC_ADDR_FMD, v & 8'h0F);
    end
    wr(`UC_ADDR_CTL, 8'h31);
    rx_count <= 2'h1;
    cyc(3);
    check(16'(rx_full_req), 16'h1);
    wr(`UC_ADDR_CTL, 8'h33);
    cyc(2);
    check(16'(rx_full_req), 16'h0);
    rx_count <= 2'h2;
    tx_buf_empty <= 1'b1;
    cyc(3);
    check(16'({rx_full_req, tx_empty_req}), 16'h3);
    wr(`UC_ADDR_CTL, 8'h23);
    cyc(2);
    check(16'(tx_empty_req), 16'h0);
    wr(`UC_ADDR_CTL, 8'h13);
    cyc(2);
    check(16'({rx_full_req, irq}), 16'h0);
    wr(`UC_ADDR_IRQ_MSK, 8'h03);
    cyc(2);
    check(16'(irq), 16'h1);
    rd(`UC_ADDR_IRQ_ST, 8'h03);
    wr(`UC_ADDR_IRQ_ST, 8'h03);
    cyc(2);
    check(16'(irq), 16'h0);
    tx_buf_empty <= 1'b0;
    cyc(2);
    tx_buf_empty <= 1'b1;
    cyc(3);
    rd(`UC_ADDR_IRQ_ST, 8'h01);
    wr(`UC_ADDR_IRQ_MSK, 8'h02);
    cyc(2);
    check(16'(irq), 16'h0);
    arst_n <= 1'b0;
    cyc(2);
    arst_n <= 1'b1;
    rd(`UC_ADDR_IRQ_MSK, 8'h00);
    rd(`UC_ADDR_CTL, 8'h00);
    wr(`UC_ADDR_CTL, 8'h01);
    for (int i = 0; i < 7; i++) begin
      wr(`UC_ADDR_BR, bd[i]);
      wr(`UC_ADDR_FMD, tr[i]);
      wr(`UC_ADDR_CLK, ck[i]);
      tick_gap(n);
      tick_gap(n);
      tick_gap(n);
      check(16'(n), gap[i]);
    end
    for (int i = 0; i < 3; i++) begin
      wr(`UC_ADDR_CLK, i == 0 ? 8'h09 : 8'h00 | 8'(i == 2));
      wr(`UC_ADDR_CTL, 8'(i != 2));
      cyc(10);
      n = 0;
      repeat (600) begin
        cyc(1);
        if (bit_tick === 1'b1) n++;
      end
      check(16'(n), 16'h0);
    end
    tx_line <= 1'b1;
    cyc(2);
    check(16'(tx_pin), 16'h1);
    wr(`UC_ADDR_EXP, 8'h01);
    cyc(2);
    check(16'({tx_pin, infrared_mode, port_active}), 16'h2);
    wr(`UC_ADDR_CTL, 8'h01);
    cyc(20);
    check(16'({port_active, tx_pin, rx_line}), 16'h5);
    // Zero bits in pulse mode: two whole bit periods of 84 cycles are counted
    tx_line <= 1'b0;
    cyc(100);
    hi = 0;
    lo = 0;
    repeat (168) begin
      cyc(1);
      hi += int'(tx_pin === 1'b1);
      lo += int'(rx_line === 1'b0);
    end
    check(16'({hi >= 24 && hi <= 32, lo >= 150}), 16'h3);
    wr(`UC_ADDR_EXP, 8'h00);
    for (int i = 0; i < 4; i++) begin
      slow_echo <= i[1];
      tx_line <= i[0];
      cyc(16);
      check(16'({tx_pin, rx_line}), {14'h0, i[0], i[0]});
    end
    stop_test();
  end
endmodule
